// >>> verilog/fcg_gate.sv
// power-down control, carrier qualification and three-wire data interface
// assumes demodulator bit, band energy and ringing flags arrive as async pins
`timescale 1ns/1ps
module fcg_gate
  import fcg_pkg::*;
#(
  parameter int unsigned BIT_CYCLES  = fcg_pkg::BIT_CYC,
  parameter int unsigned HALF_CYCLES = fcg_pkg::HALF_BIT_CYC,
  parameter int unsigned HYST_CYCLES = fcg_pkg::HYST_CYC,
  parameter int unsigned QUAL_COUNT  = fcg_pkg::QUAL_TICKS,
  parameter int unsigned DEPTH       = fcg_pkg::FIFO_DEPTH
) (
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  input  wire logic sleep_request_in,
  input  wire logic mode_in,
  input  wire logic demod_bit_in,
  input  wire logic band_energy_in,
  input  wire logic ringing_in,
  input  wire logic bit_strobe_in,
  output logic      data_out,
  output logic      bit_strobe_out,
  output logic      bit_strobe_oe_out,
  output logic      word_ready_n_out,
  output logic      word_ready_n_oe_out,
  output logic      carrier_present_n_out,
  output logic      carrier_present_n_oe_out
);
  import fcg_pkg::*;

  localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);
  localparam logic [CNT_W-1:0] HYST_LAST = CNT_W'(HYST_CYCLES - 1);
  localparam logic [7:0]       QUAL_LAST = 8'(QUAL_COUNT - 1);

  // =====================================================================
  // input synchronisers
  logic [5:0] pins_s;
  logic       sleep_s;
  logic       mode_s;
  logic       demod_s;
  logic       energy_s;
  logic       ring_s;
  logic       rd_strobe_s;

  fcg_sync #(.W(6)) u_sync (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .d_in       ({sleep_request_in, mode_in, demod_bit_in, band_energy_in, ringing_in, bit_strobe_in}),
    .q_out      (pins_s)
  );
  assign {sleep_s, mode_s, demod_s, energy_s, ring_s, rd_strobe_s} = pins_s;

  fcg_byte_if #(.W(DATA_BITS)) bif ();

  fcg_fifo #(.W(DATA_BITS), .DEPTH(DEPTH)) u_fifo (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .bif        (bif.fifo)
  );

  // =====================================================================
  // oscillator-rate tick
  logic [ACC_W-1:0] osc_acc;
  logic [ACC_W-1:0] next_osc_acc;
  logic             osc_tick;

  assign next_osc_acc = ACC_W'(osc_acc + ACC_W'(OSC_HZ));
  assign osc_tick     = (next_osc_acc >= ACC_W'(CLK_HZ));

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_acc <= '0;
    end else if (sleep_s) begin
      osc_acc <= '0;
    end else if (osc_tick) begin
      osc_acc <= ACC_W'(next_osc_acc - ACC_W'(CLK_HZ));
    end else begin
      osc_acc <= next_osc_acc;
    end
  end

  // =====================================================================
  // carrier qualification and hysteresis
  logic             carrier_on;
  logic [7:0]       qual_cnt;
  logic [CNT_W-1:0] hyst_cnt;
  logic             energy_ok;

  assign energy_ok = energy_s && !ring_s;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      carrier_on <= 1'b0;
      qual_cnt   <= '0;
      hyst_cnt   <= '0;
    end else if (sleep_s) begin
      carrier_on <= 1'b0;
      qual_cnt   <= '0;
      hyst_cnt   <= '0;
    end else if (!carrier_on) begin
      hyst_cnt <= '0;
      if (!energy_ok) begin
        qual_cnt <= '0;
      end else if (osc_tick) begin
        if (qual_cnt == QUAL_LAST) begin
          carrier_on <= 1'b1;
          qual_cnt   <= '0;
        end else begin
          qual_cnt <= 8'(qual_cnt + 1'b1);
        end
      end
    end else if (energy_ok) begin
      hyst_cnt <= '0;
    end else if (fcg_at_end(hyst_cnt, HYST_LAST)) begin
      carrier_on <= 1'b0;
      hyst_cnt   <= '0;
    end else begin
      hyst_cnt <= CNT_W'(hyst_cnt + 1'b1);
    end
  end

  // =====================================================================
  // bit timing recovery
  fcg_rx_state_t            state;
  logic [CNT_W-1:0]         bit_cnt;
  logic [2:0]               bit_idx;
  logic [DATA_BITS-1:0]     rx_byte;
  logic                     demod_q;
  logic                     bit_sample;
  logic                     byte_done;

  assign bit_sample = (state == FCG_DATA) && fcg_at_end(bit_cnt, BIT_LAST);
  assign byte_done  = (state == FCG_STOP) && fcg_at_end(bit_cnt, BIT_LAST) && demod_s;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state   <= FCG_IDLE;
      bit_cnt <= '0;
      bit_idx <= '0;
      rx_byte <= '0;
      demod_q <= 1'b1;
    end else if (sleep_s || !carrier_on) begin
      state   <= FCG_IDLE;
      bit_cnt <= '0;
      bit_idx <= '0;
      demod_q <= 1'b1;
    end else begin
      demod_q <= demod_s;
      case (state)
        FCG_IDLE: begin
          bit_cnt <= '0;
          bit_idx <= '0;
          if (demod_q && !demod_s) begin
            state <= FCG_START;
          end
        end
        FCG_START: begin
          if (fcg_at_end(bit_cnt, HALF_LAST)) begin
            bit_cnt <= '0;
            state   <= demod_s ? FCG_IDLE : FCG_DATA;
          end else begin
            bit_cnt <= CNT_W'(bit_cnt + 1'b1);
          end
        end
        FCG_DATA: begin
          if (bit_sample) begin
            bit_cnt <= '0;
            rx_byte <= {demod_s, rx_byte[DATA_BITS-1:1]};
            bit_idx <= 3'(bit_idx + 1'b1);
            if (bit_idx == 3'h7) begin
              state <= FCG_STOP;
            end
          end else begin
            bit_cnt <= CNT_W'(bit_cnt + 1'b1);
          end
        end
        FCG_STOP: begin
          if (fcg_at_end(bit_cnt, BIT_LAST)) begin
            bit_cnt <= '0;
            state   <= FCG_IDLE;
          end else begin
            bit_cnt <= CNT_W'(bit_cnt + 1'b1);
          end
        end
        default: begin
          state <= FCG_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // buffered path: push, load and read-strobe shift
  logic                 rd_strobe_q;
  logic                 strobe_rise;
  logic [DATA_BITS-1:0] shreg;
  logic [3:0]           bits_left;
  logic                 load;
  logic                 live;
  logic [CNT_W-1:0]     wr_cnt;
  logic                 next_wr_n;
  logic                 next_strobe;
  logic                 next_data;

  assign live          = carrier_on && !sleep_s;
  assign strobe_rise   = rd_strobe_s && !rd_strobe_q;
  assign bif.flush     = sleep_s;
  assign bif.pop_ready = (mode_s == MODE_BUFFER) && live && (bits_left == 4'h0) && word_ready_n_out;
  assign load          = bif.pop_ready && bif.pop_valid;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bif.push_valid <= 1'b0;
      bif.push_data  <= '0;
    end else if (sleep_s) begin
      bif.push_valid <= 1'b0;
    end else if (byte_done && mode_s == MODE_BUFFER) begin
      bif.push_valid <= 1'b1;
      bif.push_data  <= rx_byte;
    end else if (bif.push_ready) begin
      bif.push_valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_strobe_q <= 1'b0;
      shreg       <= '0;
      bits_left   <= '0;
    end else begin
      rd_strobe_q <= rd_strobe_s;
      if (sleep_s) begin
        shreg     <= '0;
        bits_left <= '0;
      end else if (load) begin
        shreg     <= bif.pop_data;
        bits_left <= 4'(DATA_BITS);
      end else if (mode_s == MODE_BUFFER && live && strobe_rise && bits_left != 4'h0) begin
        shreg     <= {1'b0, shreg[DATA_BITS-1:1]};
        bits_left <= 4'(bits_left - 1'b1);
      end
    end
  end

  // =====================================================================
  // output drive
  always_comb begin
    next_wr_n   = word_ready_n_out;
    next_strobe = bit_strobe_out;
    next_data   = data_out;
    if (sleep_s) begin
      next_wr_n   = 1'b1;
      next_strobe = 1'b1;
      next_data   = 1'b1;
    end else if (mode_s == MODE_STREAM) begin
      next_data = carrier_on ? demod_s : 1'b1;
      if (!carrier_on) begin
        next_strobe = 1'b0;
        next_wr_n   = 1'b1;
      end else begin
        if (bit_sample) begin
          next_strobe = 1'b1;
        end else if (fcg_at_end(bit_cnt, HALF_LAST) || state == FCG_IDLE) begin
          next_strobe = 1'b0;
        end
        if (byte_done) begin
          next_wr_n = 1'b0;
        end else if (fcg_at_end(wr_cnt, HALF_LAST)) begin
          next_wr_n = 1'b1;
        end
      end
    end else begin
      next_strobe = 1'b0;
      if (load) begin
        next_wr_n = 1'b0;
      end else if (!word_ready_n_out && (strobe_rise || fcg_at_end(wr_cnt, HALF_LAST))) begin
        next_wr_n = 1'b1;
      end
      if (live && strobe_rise && bits_left != 4'h0) begin
        next_data = shreg[0];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_out                 <= 1'b1;
      bit_strobe_out           <= 1'b0;
      bit_strobe_oe_out        <= 1'b0;
      word_ready_n_out         <= 1'b1;
      word_ready_n_oe_out      <= 1'b0;
      carrier_present_n_out    <= 1'b1;
      carrier_present_n_oe_out <= 1'b0;
      wr_cnt                   <= '0;
    end else begin
      data_out                 <= next_data;
      bit_strobe_out           <= next_strobe;
      bit_strobe_oe_out        <= (mode_s == MODE_STREAM);
      word_ready_n_out         <= next_wr_n;
      word_ready_n_oe_out      <= (mode_s == MODE_BUFFER) || !next_wr_n;
      carrier_present_n_out    <= !carrier_on;
      carrier_present_n_oe_out <= (mode_s == MODE_BUFFER) || carrier_on;
      wr_cnt                   <= word_ready_n_out ? '0 : CNT_W'(wr_cnt + 1'b1);
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  logic [3:0] strobe_tally;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strobe_tally <= '0;
    end else if (!word_ready_n_out || !carrier_on || state == FCG_START) begin
      strobe_tally <= '0;
    end else if (next_strobe && !bit_strobe_out) begin
      strobe_tally <= 4'(strobe_tally + 1'b1);
    end
  end

  sequence s_asleep_stream;
    sleep_s && mode_s == MODE_STREAM ##1 sleep_s && mode_s == MODE_STREAM;
  endsequence
  sequence s_read_strobe;
    mode_s == MODE_BUFFER && !sleep_s && strobe_rise && !word_ready_n_out;
  endsequence

  a_sleep_stream_park: assert property (s_asleep_stream |=> data_out && bit_strobe_out
    && !word_ready_n_oe_out && !carrier_present_n_oe_out)
    else $error("stream outputs not parked while asleep");
  a_sleep_buffer_high: assert property (sleep_s && mode_s ##1 sleep_s && mode_s |=>
    word_ready_n_out && word_ready_n_oe_out && carrier_present_n_out && carrier_present_n_oe_out)
    else $error("buffer outputs not driven high while asleep");
  a_sleep_clears_rx: assert property (sleep_s |=> !carrier_on && state == FCG_IDLE && bits_left == 4'h0)
    else $error("sleep left receiver state behind");
  a_carrier_qualified: assert property ($rose(carrier_on) |-> $past(energy_ok) && $past(qual_cnt) == QUAL_LAST)
    else $error("carrier rose without qualification");
  a_carrier_release: assert property ($fell(carrier_on) && !$past(sleep_s) |->
    $past(hyst_cnt) == HYST_LAST && !$past(energy_ok))
    else $error("carrier released early");
  a_no_carrier_idle: assert property (!carrier_on |=> state == FCG_IDLE)
    else $error("timing recovery ran without carrier");
  a_stream_quiet: assert property (!carrier_on && !sleep_s && mode_s == MODE_STREAM |=>
    data_out && !bit_strobe_out && word_ready_n_out)
    else $error("stream output active without carrier");
  a_eight_strobes: assert property ($fell(word_ready_n_out) && !$past(mode_s) |->
    strobe_tally == 4'h8)
    else $error("word ready without eight strobes");
  a_read_release: assert property (s_read_strobe |=> word_ready_n_out)
    else $error("first read strobe did not release word ready");
  a_ready_width: assert property (!word_ready_n_out |-> wr_cnt <= HALF_LAST)
    else $error("word ready held beyond half a bit");
  a_shift_order: assert property (mode_s && live && strobe_rise && bits_left != 4'h0 && !load
    |=> data_out == $past(shreg[0]) && bits_left == $past(bits_left) - 4'h1)
    else $error("read strobe shifted wrong bit");
endmodule // fcg_gate

// >>> verilog/fcg_pkg.sv
// constants and types of the caller-id receiver power and carrier gate
// assumes one 25 MHz system clock; every pin input is synchronised before use
//
// What this block does
// - controller raises sleep request; device stops its logic and ignores line input.
// - while asleep the device responds to no input but mode, which selects how the outputs are parked.
// - asleep, word ready and carrier float in mode 0, driven high in mode 1.
// - asleep in mode 0, data and bit strobe outputs sit high.
// - controller lowers sleep request; device resumes receiving.
// - carrier present asserts low only after energy is digitally qualified.
// - once present, carrier rides through short dropouts with 10 ms hysteresis.
// - carrier releases only after 10 ms with no in-band activity.
// - without carrier, bit timing recovery ignores the demodulator output.
// - mode 0 without carrier: data high, no bit strobes, no word ready.
// - mode 1 without carrier: shift register frozen, no word ready.
// - any in-band signal that raises carrier is demodulated as data.
// - ringing never triggers the carrier detector.
// - carrier qualification derives from the 3.579545 MHz oscillator rate; bit and hysteresis timing count 25 MHz clocks.
// - mark decodes as one, space as zero, in either format.
// - mode input low selects streaming mode 0, high buffered mode 1.
// - mode 0: eight strobes at data bit centres, then a word ready pulse.
// - mode 1: word ready released on first read strobe or after half bit.
// - mode 1: strobe rising edges shift byte out in received order; extras ignored.
package fcg_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned OSC_HZ       = 3_579_545;
  localparam int unsigned BAUD         = 1200;
  localparam int unsigned MARK_NA_HZ   = 1200;
  localparam int unsigned SPACE_NA_HZ  = 2200;
  localparam int unsigned MARK_EU_HZ   = 1300;
  localparam int unsigned SPACE_EU_HZ  = 2100;
  localparam int unsigned HYST_MS      = 10;
  localparam int unsigned BIT_CYC      = CLK_HZ / BAUD;
  localparam int unsigned HALF_BIT_CYC = CLK_HZ / (2 * BAUD);
  localparam int unsigned HYST_CYC     = (CLK_HZ / 1000) * HYST_MS;
  localparam int unsigned QUAL_TICKS   = 64;
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned FIFO_DEPTH   = 32;
  localparam int unsigned CNT_W        = 18;
  localparam int unsigned ACC_W        = 26;
  localparam logic        MODE_STREAM  = 1'b0;
  localparam logic        MODE_BUFFER  = 1'b1;

  typedef enum logic [1:0] {
    FCG_IDLE  = 2'b00,
    FCG_START = 2'b01,
    FCG_DATA  = 2'b10,
    FCG_STOP  = 2'b11
  } fcg_rx_state_t;

  // terminal count of an up-counter
  function automatic logic fcg_at_end(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] last);
    return cnt == last;
  endfunction
endpackage

// >>> verilog/fcg_byte_if.sv
// byte stream between the receiver and its buffer
// assumes both ends share one clock
`timescale 1ns/1ps
interface fcg_byte_if #(parameter int unsigned W = 8) ();
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  logic         flush;

  modport src  (output push_valid, push_data, pop_ready, flush,
                input  push_ready, pop_valid, pop_data);
  modport fifo (input  push_valid, push_data, pop_ready, flush,
                output push_ready, pop_valid, pop_data);
endinterface

// >>> verilog/fcg_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to ref_clk_in
`timescale 1ns/1ps
module fcg_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule // fcg_sync

// >>> verilog/fcg_fifo.sv
// byte buffer with registered read data
// assumes flush is synchronous and wins over push and pop
`timescale 1ns/1ps
module fcg_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  fcg_byte_if.fifo  bif
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          do_push;
  logic          do_fetch;

  assign bif.push_ready = (count != (AW+1)'(DEPTH));
  assign do_push        = bif.push_valid && bif.push_ready;
  assign do_fetch       = (count != '0) && (!bif.pop_valid || bif.pop_ready);

  always_ff @(posedge ref_clk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= bif.push_data;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (bif.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (do_fetch) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= (AW+1)'(count + do_push - do_fetch);
    end
  end

  // output stage: read data from a register
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bif.pop_valid <= 1'b0;
      bif.pop_data  <= '0;
    end else if (bif.flush) begin
      bif.pop_valid <= 1'b0;
    end else if (do_fetch) begin
      bif.pop_valid <= 1'b1;
      bif.pop_data  <= mem[rd_ptr];
    end else if (bif.pop_ready) begin
      bif.pop_valid <= 1'b0;
    end
  end
endmodule // fcg_fifo

// >>> testbench/fcg_mcu_model.sv
// controller model: reads a buffered byte with read strobes
// assumes word ready low announces a byte while enable is high
`timescale 1ns/1ps
module fcg_mcu_model (
  input  wire logic       enable_in,
  input  wire logic       word_ready_n_in,
  input  wire logic       data_in,
  output logic            strobe_out,
  output logic [7:0]      byte_out,
  output logic            early_out,
  output logic            hold_out,
  output logic            done_out
);
  // =====================================================
  // read sequence, 320 ns strobe period, idle low between frames
  initial begin
    int   k;
    logic last;
    strobe_out = 1'b0;
    byte_out   = 8'h00;
    early_out  = 1'b0;
    hold_out   = 1'b0;
    done_out   = 1'b0;
    forever begin
      @(negedge word_ready_n_in);
      if (enable_in) begin
        done_out = 1'b0;
        #100;
        for (k = 0; k < 9; k++) begin
          strobe_out = 1'b1;
          #160;
          strobe_out = 1'b0;
          #140;
          if (k < 8) byte_out[k] = data_in;
          if (k == 0) early_out = word_ready_n_in;
          if (k == 7) last = data_in;
          if (k == 8) hold_out = (data_in === last);
          #20;
        end
        done_out = 1'b1;
      end
    end
  end
endmodule // fcg_mcu_model

// >>> testbench/test_fcg_gate.sv
// self-checking bench of the power and carrier gate
// assumes small counts: bit 40, half 20, hysteresis 200, qualify 4
`timescale 1ns/1ps
module test_fcg_gate;
  import fcg_pkg::*;
  localparam int unsigned BITC = 40;
  localparam int unsigned HALFC = 20;
  localparam int unsigned HYSTC = 200;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic sleep_request_in = 1'b0;
  logic mode_in = 1'b0;
  logic demod_bit_in = 1'b1;
  logic band_energy_in = 1'b0;
  logic ringing_in = 1'b0;
  logic strobe_pin, data_out, bit_strobe_out, bit_strobe_oe_out;
  logic word_ready_n_out, word_ready_n_oe_out, carrier_present_n_out, carrier_present_n_oe_out;
  logic [7:0] mcu_byte, cap = 8'h00;
  logic mcu_early, mcu_hold, mcu_done, strobe_q = 1'b0, wr_q = 1'b1;
  int n_errors = 0, cmp_count = 0, n_strobe = 0, n_wr = 0, wr_len = 0, wr_cnt = 0, n_low = 0;

  always #20 ref_clk_in = ~ref_clk_in;

  fcg_gate #(.BIT_CYCLES(BITC), .HALF_CYCLES(HALFC), .HYST_CYCLES(HYSTC), .QUAL_COUNT(4),
    .DEPTH(32)) fcg_gate_i (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sleep_request_in(sleep_request_in),
    .mode_in(mode_in), .demod_bit_in(demod_bit_in), .band_energy_in(band_energy_in),
    .ringing_in(ringing_in), .bit_strobe_in(strobe_pin), .data_out(data_out),
    .bit_strobe_out(bit_strobe_out), .bit_strobe_oe_out(bit_strobe_oe_out),
    .word_ready_n_out(word_ready_n_out), .word_ready_n_oe_out(word_ready_n_oe_out),
    .carrier_present_n_out(carrier_present_n_out), .carrier_present_n_oe_out(carrier_present_n_oe_out));

  fcg_mcu_model fcg_mcu_model_i (.enable_in(mode_in), .word_ready_n_in(word_ready_n_out),
    .data_in(data_out), .strobe_out(strobe_pin), .byte_out(mcu_byte), .early_out(mcu_early),
    .hold_out(mcu_hold), .done_out(mcu_done));

  // =====================================================
  // output monitor: strobes, captured bits, word ready width
  always @(posedge ref_clk_in) begin
    strobe_q <= bit_strobe_out;
    wr_q <= word_ready_n_out;
    if (data_out === 1'b0) n_low <= n_low + 1;
    if (bit_strobe_out && !strobe_q && bit_strobe_oe_out) begin
      n_strobe <= n_strobe + 1;
      cap <= {data_out, cap[7:1]};
    end
    if (word_ready_n_out === 1'b0) wr_cnt <= wr_cnt + 1;
    if (!wr_q && word_ready_n_out) begin
      n_wr <= n_wr + 1;
      wr_len <= wr_cnt;
      wr_cnt <= 0;
    end
  end

  // =====================================================
  // shared tasks
  task automatic report_and_stop();
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  task automatic wait_cd(input logic lvl, input int lim);
    for (int i = 0; i < lim && carrier_present_n_out !== lvl; i++) cyc(1);
    chk(carrier_present_n_out, lvl, "carrier wait ran out");
    if (carrier_present_n_out !== lvl) report_and_stop();
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      demod_bit_in <= f[k];
      cyc(BITC);
    end
    cyc(2 * BITC);
  endtask

  // =====================================================
  // scenarios
  task automatic t_qualify();
    band_energy_in <= 1'b1;
    ringing_in <= 1'b1;
    cyc(80);
    chk(carrier_present_n_out, 1'b1, "carrier on ringing");
    ringing_in <= 1'b0;
    cyc(8);
    chk(carrier_present_n_out, 1'b1, "carrier too early");
    wait_cd(1'b0, 100);
  endtask

  task automatic t_rx0();
    int s, w;
    s = n_strobe;
    w = n_wr;
    send_byte(8'hA5);
    chk(n_strobe - s, 8'd8, "strobe count");
    chk(cap, 8'hA5, "mode 0 byte");
    chk(n_wr - w, 8'd1, "word ready count");
    chk(wr_len, HALFC, "word ready width");
  endtask

  task automatic t_hyst();
    int s, w, l;
    band_energy_in <= 1'b0;
    cyc(HYSTC - 50);
    band_energy_in <= 1'b1;
    cyc(20);
    chk(carrier_present_n_out, 1'b0, "dropout released carrier");
    band_energy_in <= 1'b0;
    cyc(HYSTC - 20);
    chk(carrier_present_n_out, 1'b0, "carrier released early");
    wait_cd(1'b1, 60);
    s = n_strobe;
    w = n_wr;
    l = n_low;
    send_byte(8'h00);
    chk(n_strobe - s, 8'd0, "strobe without carrier");
    chk(n_wr - w, 8'd0, "word ready without carrier");
    chk(n_low - l, 8'd0, "data low without carrier");
  endtask

  task automatic t_rx1();
    int i;
    mode_in <= 1'b1;
    band_energy_in <= 1'b1;
    wait_cd(1'b0, 100);
    send_byte(8'h3C);
    for (i = 0; i < 200 && mcu_done !== 1'b1; i++) cyc(1);
    chk(mcu_done, 1'b1, "read never finished");
    if (mcu_done !== 1'b1) report_and_stop();
    chk(mcu_byte, 8'h3C, "mode 1 byte");
    chk(mcu_early, 1'b1, "word ready held past strobe");
    chk(mcu_hold, 1'b1, "extra strobe shifted");
  endtask

  task automatic t_sleep();
    mode_in <= 1'b0;
    cyc(4);
    sleep_request_in <= 1'b1;
    cyc(6);
    chk({data_out, bit_strobe_out, word_ready_n_oe_out, carrier_present_n_oe_out}, 8'hC,
      "mode 0 parking");
    mode_in <= 1'b1;
    cyc(6);
    chk({word_ready_n_out, word_ready_n_oe_out, carrier_present_n_out, carrier_present_n_oe_out},
      8'hF, "mode 1 parking");
    cyc(60);
    chk(carrier_present_n_out, 1'b1, "carrier while asleep");
    sleep_request_in <= 1'b0;
    cyc(5);
    chk(carrier_present_n_out, 1'b1, "carrier kept over wake");
    wait_cd(1'b0, 100);
  endtask

  // =====================================================
  // main sequence
  initial begin
    cyc(12);
    nrst_in <= 1'b1;
    cyc(4);
    t_qualify();
    t_rx0();
    t_hyst();
    t_rx1();
    t_sleep();
    report_and_stop();
  end
endmodule // test_fcg_gate
